// ===== hdl/pap_path_fsm.sv
`timescale 1ns/10ps
// path-control state machine of the access-side telephony port
// assumes peer message strobes are single-cycle and on i_ref_clk;
// assumes the line condition input is already synchronous

// Function
// - classify line condition by state into group
// - machine takes only grouped line events
// - export current state to classifier
// - seize in idle: timer, establish, path-initiated
// - hangup in initiated goes abort, else ignored
// - line signal in active: send signal
// - signal sequence error: disconnect, error report
// - received signal: forward, start response timer
// - response timer expiry sends signal ack
// - supervision expiry: error and disconnect
module pap_path_fsm
	import pap_pkg::*;
(
	// clock and reset
	input  wire logic                    i_ref_clk,
	input  wire logic                    i_nrst,
	// line side
	input  wire logic                    i_lc_valid,
	input  wire pap_pkg::pap_line_cond_e i_lc_code,
	// peer messages received
	input  wire logic                    i_rx_establish,
	input  wire logic                    i_rx_establish_ack,
	input  wire logic                    i_rx_signal,
	input  wire logic                    i_rx_signal_bad,
	input  wire logic                    i_rx_disconnect,
	input  wire logic                    i_rx_disconnect_complete,
	// local management
	input  wire logic                    i_port_block,
	input  wire logic                    i_port_unblock,
	input  wire logic                    i_tx_seq_error,
	// messages sent
	output logic                         o_tx_establish,
	output logic                         o_tx_establish_ack,
	output logic                         o_tx_signal,
	output logic                         o_tx_signal_ack,
	output logic                         o_tx_disconnect,
	output logic                         o_tx_disconnect_complete,
	// line and management side
	output logic                         o_line_signal_fwd,
	output logic                         o_bearer_transparent,
	output logic                         o_mgmt_error_report,
	output logic [pap_pkg::ST_W-1:0]     o_state
);
	// ========================================
	// timer limits, in cycles
	localparam logic [TMR_W-1:0] EST_CYC     = TMR_W'(EST_TIME_MS * CYC_PER_MS);
	localparam logic [TMR_W-1:0] EST_REP_CYC = TMR_W'(EST_REP_TIME_MS * CYC_PER_MS);
	localparam logic [TMR_W-1:0] DISC_CYC    = TMR_W'(DISC_TIME_MS * CYC_PER_MS);
	localparam logic [TMR_W-1:0] SUP_CYC     = TMR_W'(ACK_SUP_TIME_MS * CYC_PER_MS);
	localparam logic [TMR_W-1:0] RSP_CYC     = TMR_W'(ACK_RSP_TIME_MS * CYC_PER_MS);

	pap_evt_if evt ();
	pap_state_e state, next_state;

	// ========================================
	// classifier kept apart; it sees our state
	pap_line_classifier u_cls (
		.i_ref_clk (i_ref_clk),
		.i_nrst    (i_nrst),
		.i_lc_valid(i_lc_valid),
		.i_lc_code (i_lc_code),
		.evt       (evt.classifier)
	);
	assign evt.cur_state = state;

	// ========================================
	// timers: one counter for establish/disconnect, two for signal acks
	logic [TMR_W-1:0] est_cnt, sup_cnt, rsp_cnt;
	logic             est_run, sup_run, rsp_run, est_rep;
	logic [1:0]       disc_tries;
	logic             est_done, sup_done, rsp_done;
	assign est_done = est_run && (est_cnt == 1);
	assign sup_done = sup_run && (sup_cnt == 1);
	assign rsp_done = rsp_run && (rsp_cnt == 1);

	// only grouped events reach the transition logic
	logic seize, info, hang, lsig;
	assign seize = evt.line_seize_event;
	assign info  = evt.line_info_event;
	assign hang  = evt.line_hangup_event;
	assign lsig  = evt.line_signalling_event;

	// ========================================
	// transition decode
	logic is_act;
	logic act_sig_err, act_sig_ok, act_rx_bad, act_sup_to;
	logic go_idle_disc, go_disc_req, est_start, est_stop, disc_start;
	assign is_act       = (state == state_path_active);
	assign act_sig_ok   = is_act && lsig && !i_tx_seq_error;
	assign act_sig_err  = is_act && lsig && i_tx_seq_error;
	assign act_rx_bad   = is_act && i_rx_signal && i_rx_signal_bad;
	assign act_sup_to   = is_act && sup_done;
	assign go_idle_disc = i_rx_disconnect && (state == state_path_initiated
	                      || state == state_path_abort || is_act
	                      || state == state_line_info);
	assign go_disc_req  = !go_idle_disc && (act_sig_err || act_rx_bad || act_sup_to
	                      || (state == state_path_abort && i_rx_establish_ack));
	// a block in the same cycle wins, so no establish goes out and no timer is left running
	assign est_start    = (state == state_idle) && (seize || info) && !i_port_block;
	assign est_stop     = go_idle_disc || go_disc_req || i_rx_establish_ack || i_rx_establish;
	assign disc_start   = go_disc_req;

	// next state
	always_comb begin
		next_state = state;
		if (i_port_block) begin
			next_state = state_port_blocked;
		end else if (go_idle_disc) begin
			next_state = state_idle;
		end else if (go_disc_req) begin
			next_state = state_disconnect_req;
		end else begin
			unique case (state)
				state_out_of_service: next_state = state_out_of_service;
				state_idle: begin
					if (seize) next_state = state_path_initiated;
					else if (info) next_state = state_line_info;
					else if (i_rx_establish) next_state = state_path_active;
				end
				state_path_initiated: begin
					if (i_rx_establish_ack || i_rx_establish) next_state = state_path_active;
					else if (hang) next_state = state_path_abort;
					else if (i_rx_disconnect_complete) next_state = state_idle;
				end
				state_path_abort: begin
					if (seize) next_state = state_path_initiated;
					else if (i_rx_establish) next_state = state_path_active;
					else if (i_rx_disconnect_complete || est_done) next_state = state_idle;
				end
				state_line_info: if (i_rx_disconnect_complete) next_state = state_idle;
				state_path_active: if (i_rx_disconnect_complete) next_state = state_idle;
				state_port_blocked: if (i_port_unblock) next_state = state_idle;
				state_disconnect_req: if (i_rx_disconnect || i_rx_disconnect_complete) next_state = state_idle;
				default: next_state = state_idle;
			endcase
		end
	end

	// output decode, registered below
	logic n_est, n_est_ack, n_sig, n_sack, n_disc, n_dcomp, n_fwd, n_err, n_bt;
	assign n_est   = est_start || (est_done && (state == state_path_initiated || state == state_line_info));
	assign n_est_ack = i_rx_establish && (state == state_idle || state == state_path_initiated
	                   || state == state_path_abort);
	assign n_sig   = is_act && lsig;
	assign n_sack  = is_act && rsp_done;
	assign n_disc  = go_disc_req || ((state == state_disconnect_req) && est_done);
	assign n_dcomp = i_rx_disconnect && (state == state_idle || go_idle_disc)
	                 || (state == state_path_abort && est_done) || (i_port_block && state != state_port_blocked
	                 && state != state_idle && state != state_out_of_service);
	assign n_fwd   = (seize && (state == state_idle || state == state_path_abort)) || act_sig_ok
	                 || (is_act && i_rx_signal && !i_rx_signal_bad);
	assign n_err   = act_sig_err || act_rx_bad || act_sup_to
	                 || ((state == state_disconnect_req) && est_done && disc_tries == 2'(DISC_MAX_RETRY - 1));
	assign n_bt    = (next_state == state_path_active);

	// state and outputs
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state                    <= state_idle;
			o_tx_establish           <= 1'b0;
			o_tx_establish_ack       <= 1'b0;
			o_tx_signal              <= 1'b0;
			o_tx_signal_ack          <= 1'b0;
			o_tx_disconnect          <= 1'b0;
			o_tx_disconnect_complete <= 1'b0;
			o_line_signal_fwd        <= 1'b0;
			o_bearer_transparent     <= 1'b0;
			o_mgmt_error_report      <= 1'b0;
			o_state                  <= ST_W'(state_idle);
		end else begin
			state                    <= next_state;
			o_tx_establish           <= n_est;
			o_tx_establish_ack       <= n_est_ack;
			o_tx_signal              <= n_sig;
			o_tx_signal_ack          <= n_sack;
			o_tx_disconnect          <= n_disc;
			o_tx_disconnect_complete <= n_dcomp;
			o_line_signal_fwd        <= n_fwd;
			o_bearer_transparent     <= n_bt;      // non-transparent outside path active
			o_mgmt_error_report      <= n_err;
			o_state                  <= next_state;
		end
	end

	// establish / disconnect counter; establish repeat period after first expiry, disconnect period reloaded on each expiry
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			est_run <= 1'b0; est_cnt <= '0; est_rep <= 1'b0; disc_tries <= '0;
		end else if (disc_start || (est_done && state == state_disconnect_req)) begin
			est_run <= 1'b1; est_cnt <= DISC_CYC; est_rep <= 1'b0;
			disc_tries <= disc_start ? 2'h0 : disc_tries + 2'h1;
		end else if (est_start) begin
			est_run <= 1'b1; est_cnt <= EST_CYC; est_rep <= 1'b0;
		end else if (est_stop || next_state == state_idle || i_port_block) begin
			est_run <= 1'b0; est_cnt <= '0;
		end else if (est_done) begin
			est_run <= 1'b1; est_cnt <= EST_REP_CYC; est_rep <= 1'b1;
		end else if (est_run) begin
			est_cnt <= est_cnt - TMR_W'(1);
		end
	end

	// supervision timer: started by a sent signal, stopped on leaving active
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			sup_run <= 1'b0; sup_cnt <= '0;
		end else if (next_state != state_path_active || sup_done) begin
			sup_run <= 1'b0; sup_cnt <= '0;
		end else if (act_sig_ok && !sup_run) begin
			sup_run <= 1'b1; sup_cnt <= SUP_CYC;
		end else if (sup_run) begin
			sup_cnt <= sup_cnt - TMR_W'(1);
		end
	end

	// response timer: started by a good received signal if idle
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			rsp_run <= 1'b0; rsp_cnt <= '0;
		end else if (next_state != state_path_active) begin
			rsp_run <= 1'b0; rsp_cnt <= '0;
		end else if (is_act && i_rx_signal && !i_rx_signal_bad && (!rsp_run || rsp_done)) begin
			// expiry stops the timer, so a signal arriving then starts it afresh
			rsp_run <= 1'b1; rsp_cnt <= RSP_CYC;
		end else if (rsp_done) begin
			rsp_run <= 1'b0; rsp_cnt <= '0;
		end else if (rsp_run) begin
			rsp_cnt <= rsp_cnt - TMR_W'(1);
		end
	end

	// ========================================
	// checks
	chk_seize_idle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(state == state_idle && seize && !i_port_block) |=> (state == state_path_initiated) && o_tx_establish
		&& est_run) else $error("seize in idle mishandled");
	chk_hangup_init: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		(state == state_path_initiated && hang && !i_port_block && !i_rx_disconnect && !i_rx_establish_ack
		&& !i_rx_establish) |=> state == state_path_abort) else $error("hangup not to abort");
	chk_signal_send: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		act_sig_ok && !i_port_block && !go_idle_disc && !go_disc_req |=> o_tx_signal && o_line_signal_fwd
		&& sup_run && state == state_path_active) else $error("signal send wrong");
	chk_seq_error: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		act_sig_err && !i_port_block && !i_rx_disconnect |=> o_tx_disconnect && o_mgmt_error_report
		&& state == state_disconnect_req && !sup_run && !rsp_run) else $error("sequence error wrong");
	chk_rx_signal: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		is_act && i_rx_signal && !i_rx_signal_bad && next_state == state_path_active |=> o_line_signal_fwd
		&& rsp_run) else $error("received signal wrong");
	chk_rsp_expire: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		is_act && rsp_done |=> o_tx_signal_ack) else $error("no signal ack");
	chk_sup_expire: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		is_act && sup_done && !i_port_block && !i_rx_disconnect |=> o_mgmt_error_report && o_tx_disconnect
		&& !rsp_run) else $error("supervision expiry wrong");
	chk_disc_idle: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		go_idle_disc && !i_port_block |=> state == state_idle && o_tx_disconnect_complete && !est_run
		&& !sup_run) else $error("disconnect not handled");
	chk_est_ack: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		state == state_path_initiated && i_rx_establish_ack && !i_rx_disconnect && !i_port_block
		|=> state == state_path_active && o_bearer_transparent && !est_run) else $error("establish ack wrong");
endmodule // pap_path_fsm

// ===== include/pap_pkg.sv
// package for the access-side path-control state machine
// assumes a single 50 MHz clock domain and no software registers
package pap_pkg;

	// ========================================
	// clock and timer durations
	localparam int unsigned CLK_MHZ         = 50;
	localparam int unsigned EST_TIME_MS     = 4000;   // establish timer
	localparam int unsigned EST_REP_TIME_MS = 5000;   // establish repeat timer
	localparam int unsigned DISC_TIME_MS    = 2000;   // disconnect timer
	localparam int unsigned ACK_SUP_TIME_MS = 10000;  // ack supervision timer
	localparam int unsigned ACK_RSP_TIME_MS = 5000;   // ack response timer
	localparam int unsigned CYC_PER_MS      = CLK_MHZ * 1000;
	localparam int unsigned TMR_W           = 32;
	localparam int unsigned DISC_MAX_RETRY  = 3;      // third expiry reports error

	// ========================================
	// states, one-hot
	localparam int unsigned ST_W = 8;
	typedef enum logic [ST_W-1:0] {
		state_out_of_service = 8'h01,
		state_idle           = 8'h02,
		state_path_initiated = 8'h04,
		state_path_abort     = 8'h08,
		state_line_info      = 8'h10,
		state_path_active    = 8'h20,
		state_port_blocked   = 8'h40,
		state_disconnect_req = 8'h80
	} pap_state_e;

	// ========================================
	// line-condition codes from the analogue side
	localparam int unsigned LC_W = 3;
	typedef enum logic [LC_W-1:0] {
		lc_none     = 3'h0,
		lc_off_hook = 3'h1,
		lc_on_hook  = 3'h2,
		lc_flash    = 3'h3,
		lc_digit    = 3'h4,
		lc_ring_trip= 3'h5
	} pap_line_cond_e;

endpackage

// ===== include/pap_evt_if.sv
`timescale 1ns/10ps
// grouped line events passed from the classifier to the path machine
// assumes classifier and machine share one clock
interface pap_evt_if;
	logic line_seize_event;
	logic line_info_event;
	logic line_hangup_event;
	logic line_signalling_event;
	logic [7:0] cur_state;

	modport classifier (
		output line_seize_event, line_info_event, line_hangup_event, line_signalling_event,
		input  cur_state
	);
	modport machine (
		input  line_seize_event, line_info_event, line_hangup_event, line_signalling_event,
		output cur_state
	);
endinterface // pap_evt_if

// ===== hdl/pap_line_classifier.sv
`timescale 1ns/10ps
// state-dependent grouping of analogue line conditions into events
// assumes line condition strobe is on the same clock as the machine
module pap_line_classifier
	import pap_pkg::*;
(
	// clock and reset
	input  wire logic                 i_ref_clk,
	input  wire logic                 i_nrst,
	// line condition
	input  wire logic                 i_lc_valid,
	input  wire pap_pkg::pap_line_cond_e i_lc_code,
	// to machine
	pap_evt_if.classifier             evt
);
	// ========================================
	// classification
	pap_state_e st;
	logic       is_idle;
	logic       is_init;
	logic       is_abort;
	logic       is_active;
	logic       next_seize;
	logic       next_info;
	logic       next_hang;
	logic       next_sig;

	// state from the machine steers grouping
	assign st        = pap_state_e'(evt.cur_state);
	assign is_idle   = (st == state_idle);
	assign is_init   = (st == state_path_initiated);
	assign is_abort  = (st == state_path_abort);
	assign is_active = (st == state_path_active);
	// at most one group per condition, chosen by state
	assign next_seize = i_lc_valid && (is_idle || is_abort) && (i_lc_code == lc_off_hook);
	assign next_info  = i_lc_valid && is_idle && (i_lc_code == lc_digit);
	assign next_hang  = i_lc_valid && is_init && (i_lc_code == lc_on_hook);
	assign next_sig   = i_lc_valid && !next_seize && !next_info && !next_hang
	                    && (is_active || is_init || is_abort) && (i_lc_code != lc_none);

	// one-cycle event pulses
	always_ff @(posedge i_ref_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			evt.line_seize_event      <= 1'b0;
			evt.line_info_event       <= 1'b0;
			evt.line_hangup_event     <= 1'b0;
			evt.line_signalling_event <= 1'b0;
		end else begin
			evt.line_seize_event      <= next_seize;
			evt.line_info_event       <= next_info;
			evt.line_hangup_event     <= next_hang;
			evt.line_signalling_event <= next_sig;
		end
	end

	chk_one_group: assert property (@(posedge i_ref_clk) disable iff (!i_nrst)
		$onehot0({next_seize, next_info, next_hang, next_sig})) else $error("two event groups at once");
endmodule // pap_line_classifier

// ===== verif/pap_exch_model.sv
// exchange-side stand-in that sends peer messages to the path machine
// assumes the bench holds each command for exactly one clock cycle
`timescale 1ns/10ps
module pap_exch_model (
	// clock and reset
	input  wire logic       i_ref_clk,
	input  wire logic       i_nrst,
	// bench control: 1 establish, 2 signal, 3 bad signal, 4 disconnect, 5 disconnect complete
	input  wire logic       i_auto,
	input  wire logic [3:0] i_delay,
	input  wire logic [2:0] i_cmd,
	// messages from the access side
	input  wire logic       i_tx_establish,
	input  wire logic       i_tx_disconnect,
	// messages towards the access side
	output logic            o_rx_establish,
	output logic            o_rx_establish_ack,
	output logic            o_rx_signal,
	output logic            o_rx_signal_bad,
	output logic            o_rx_disconnect,
	output logic            o_rx_disconnect_complete
);
	// ========================================
	// answer state
	logic [2:0] cmd;
	logic       saw_est;
	logic       saw_disc;
	int         ack_cnt = 0;
	int         dc_cnt  = 0;

	// sample at the edge, launch pulses just after it so the machine sees them next edge
	always @(posedge i_ref_clk) begin
		cmd      = i_cmd;
		saw_est  = i_tx_establish;
		saw_disc = i_tx_disconnect;
		#1;
		o_rx_establish           = i_nrst && (cmd == 3'h1);
		o_rx_signal              = i_nrst && ((cmd == 3'h2) || (cmd == 3'h3));
		o_rx_signal_bad          = i_nrst && (cmd == 3'h3);
		o_rx_disconnect          = i_nrst && (cmd == 3'h4);
		o_rx_establish_ack       = i_nrst && (ack_cnt == 1);
		o_rx_disconnect_complete = i_nrst && ((cmd == 3'h5) || (dc_cnt == 1));
		// a slow exchange answers only after i_delay cycles
		if (ack_cnt != 0) ack_cnt--;
		if (dc_cnt != 0) dc_cnt--;
		if (i_auto && saw_est) ack_cnt = int'(i_delay);
		if (i_auto && saw_disc) dc_cnt = int'(i_delay);
	end
endmodule // pap_exch_model

// ===== verif/pap_path_fsm_tb_top.sv
// self-checking bench for the access-side path-control machine
// assumes the exchange stand-in model is compiled ahead of this file
`timescale 1ns/10ps
module pap_path_fsm_tb_top;
	import pap_pkg::*;

	// ========================================
	// notes of expected results
	typedef struct packed {
		logic [7:0] pulses;
		logic [7:0] mask;
		logic [7:0] state;
		logic       bearer;
	} pap_note_s;
	localparam logic [7:0] P_EST = 8'h80;
	localparam logic [7:0] P_EACK = 8'h40;
	localparam logic [7:0] P_SIG = 8'h20;
	localparam logic [7:0] P_DISC = 8'h08;
	localparam logic [7:0] P_DCOMP = 8'h04;
	localparam logic [7:0] P_FWD = 8'h02;
	localparam logic [7:0] P_ERR = 8'h01;
	localparam int LIMIT = 20000;
	pap_note_s  notes[$];
	pap_note_s  cur;
	int         failures = 0;
	int         comparisons = 0;
	int         cycles = 0;
	int         seed = 32'hc6e0;
	logic [7:0] pulses;
	logic [7:0] prev_state;
	logic       prev_bearer;

	// ========================================
	// design and partner signals
	logic i_ref_clk, i_nrst, i_lc_valid, i_port_block, i_port_unblock, i_tx_seq_error, auto;
	logic [3:0] delay;
	logic [2:0] cmd;
	pap_line_cond_e i_lc_code;
	logic rx_est, rx_eack, rx_sig, rx_bad, rx_disc, rx_dcomp;
	logic tx_est, tx_eack, tx_sig, tx_sack, tx_disc, tx_dcomp, fwd, bearer, err;
	logic [ST_W-1:0] state;

	pap_path_fsm dut_u (
		.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_lc_valid(i_lc_valid), .i_lc_code(i_lc_code),
		.i_rx_establish(rx_est), .i_rx_establish_ack(rx_eack), .i_rx_signal(rx_sig),
		.i_rx_signal_bad(rx_bad), .i_rx_disconnect(rx_disc), .i_rx_disconnect_complete(rx_dcomp),
		.i_port_block(i_port_block), .i_port_unblock(i_port_unblock), .i_tx_seq_error(i_tx_seq_error),
		.o_tx_establish(tx_est), .o_tx_establish_ack(tx_eack), .o_tx_signal(tx_sig),
		.o_tx_signal_ack(tx_sack), .o_tx_disconnect(tx_disc), .o_tx_disconnect_complete(tx_dcomp),
		.o_line_signal_fwd(fwd), .o_bearer_transparent(bearer), .o_mgmt_error_report(err),
		.o_state(state)
	);
	pap_exch_model exch_u (
		.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_auto(auto), .i_delay(delay), .i_cmd(cmd),
		.i_tx_establish(tx_est), .i_tx_disconnect(tx_disc), .o_rx_establish(rx_est),
		.o_rx_establish_ack(rx_eack), .o_rx_signal(rx_sig), .o_rx_signal_bad(rx_bad),
		.o_rx_disconnect(rx_disc), .o_rx_disconnect_complete(rx_dcomp)
	);

	// 50 MHz clock
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end

	// ========================================
	// tasks
	task automatic results();
		if (notes.size() != 0) failures++;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [7:0] exp_v, input logic [7:0] got);
		comparisons++;
		if (got !== exp_v) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", what, exp_v, got);
		end
	endtask
	task automatic note(input logic [7:0] p, input logic [7:0] st, input logic br, input logic [7:0] m = 8'hFF);
		notes.push_back('{pulses: p, mask: m, state: st, bearer: br});
	endtask
	task automatic lc(input logic [2:0] code);
		@(posedge i_ref_clk);
		#1;
		i_lc_valid = 1'b1;
		i_lc_code  = pap_line_cond_e'(code);
		@(posedge i_ref_clk);
		#1;
		i_lc_valid = 1'b0;
	endtask
	task automatic peer(input logic [2:0] c);
		@(posedge i_ref_clk);
		#1;
		cmd = c;
		@(posedge i_ref_clk);
		#1;
		cmd = 3'h0;
	endtask
	task automatic mgmt(input logic blk);
		@(posedge i_ref_clk);
		#1;
		i_port_block   = blk;
		i_port_unblock = !blk;
		@(posedge i_ref_clk);
		#1;
		i_port_block   = 1'b0;
		i_port_unblock = 1'b0;
	endtask
	// bounded wait for the notes to be used up, then a few quiet cycles for stray results
	task automatic drain();
		for (int i = 0; i < 60 && notes.size() != 0; i++) @(posedge i_ref_clk);
		repeat (4) @(posedge i_ref_clk);
		// later level changes land off the sampling edge
		#1;
	endtask

	// ========================================
	// monitor: any pulse or level change is a result and uses the oldest note
	always @(posedge i_ref_clk) begin
		#2;
		pulses = {tx_est, tx_eack, tx_sig, tx_sack, tx_disc, tx_dcomp, fwd, err};
		if (!i_nrst) begin
			prev_state  = state;
			prev_bearer = bearer;
		end else if (pulses != 8'h00 || state !== prev_state || bearer !== prev_bearer) begin
			if (notes.size() == 0) begin
				failures++;
				$display("[FAIL] unexpected result expected none seen %h %h", pulses, state);
			end else begin
				cur = notes.pop_front();
				cmp("pulses", cur.pulses & cur.mask, pulses & cur.mask);
				cmp("state", cur.state, state);
				cmp("bearer", {7'h00, cur.bearer}, {7'h00, bearer});
			end
			prev_state  = state;
			prev_bearer = bearer;
		end
	end

	// hang guard
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == LIMIT) begin
			failures++;
			results();
		end
	end

	// ========================================
	// main sequence
	initial begin
		{i_nrst, i_lc_valid, i_port_block, i_port_unblock, i_tx_seq_error, auto} = 6'h00;
		i_lc_code = lc_none;
		cmd       = 3'h0;
		delay     = 4'h1;
		repeat (10) @(posedge i_ref_clk);
		#1;
		i_nrst = 1'b1;
		// conditions that are not seize or info in idle do nothing
		lc(3'h2);
		lc(3'h3);
		lc(3'h5);
		drain();
		note(P_EST | P_FWD, state_path_initiated, 1'b0);
		lc(3'h1);
		note(8'h00, state_path_abort, 1'b0);
		lc(3'h2);
		note(P_DCOMP, state_idle, 1'b0);
		peer(3'h4);
		note(P_EST | P_FWD, state_path_initiated, 1'b0);
		lc(3'h1);
		note(P_DCOMP, state_idle, 1'b0);
		peer(3'h4);
		drain();
		// slow exchange acknowledges after a random delay
		auto  = 1'b1;
		delay = 4'($unsigned($random(seed)) % 8 + 1);
		note(P_EST | P_FWD, state_path_initiated, 1'b0);
		note(8'h00, state_path_active, 1'b1);
		lc(3'h1);
		drain();
		auto = 1'b0;
		for (int i = 0; i < 4; i++) begin
			note(P_SIG | P_FWD, state_path_active, 1'b1);
			lc(3'($unsigned($random(seed)) % 5 + 1));
		end
		note(P_FWD, state_path_active, 1'b1);
		peer(3'h2);
		note(P_FWD, state_path_active, 1'b1);
		peer(3'h2);
		note(P_DCOMP, state_idle, 1'b0);
		peer(3'h4);
		drain();
		// sequence overflow while sending, then peer completes the disconnect
		note(P_EACK, state_path_active, 1'b1);
		peer(3'h1);
		i_tx_seq_error = 1'b1;
		note(P_SIG | P_ERR | P_DISC, state_disconnect_req, 1'b0);
		lc(3'h3);
		drain();
		i_tx_seq_error = 1'b0;
		note(8'h00, state_idle, 1'b0);
		peer(3'h5);
		// out-of-sequence received signal, exchange answers on its own
		auto = 1'b1;
		note(P_EACK, state_path_active, 1'b1);
		peer(3'h1);
		note(P_ERR | P_DISC, state_disconnect_req, 1'b0);
		note(8'h00, state_idle, 1'b0);
		peer(3'h3);
		drain();
		auto = 1'b0;
		// line information state ignores a release
		note(P_EST, state_line_info, 1'b0);
		lc(3'h4);
		lc(3'h2);
		note(P_DCOMP, state_idle, 1'b0);
		peer(3'h4);
		note(8'h00, state_port_blocked, 1'b0);
		mgmt(1'b1);
		note(8'h00, state_idle, 1'b0);
		mgmt(1'b0);
		drain();
		results();
	end
endmodule // pap_path_fsm_tb_top
